// *** shared/cpu_regs_defines.svh ***
// Constants for the processor pointer register set
`ifndef CPU_REGS_DEFINES_SVH
`define CPU_REGS_DEFINES_SVH

`define CORE_CLK_PERIOD_NS 100
`define MAP_ADDR_BITS 13
`define STACK_PTR_BITS 6
`define STACK_FIXED_BITS 10'h003
`define STACK_PTR_RESET 6'h3F
`define STACK_TOP_ADDR 16'h00FF
`define STACK_BOTTOM_ADDR 16'h00C0
`define CALL_FRAME_BYTES 3'h2
`define IRQ_FRAME_BYTES 3'h5
`define PC_RESET_VALUE 16'h0000

`endif

// *** shared/cpu_regs_pkg.sv ***
// Types shared by the pointer register set and its sequencer
package cpu_regs_pkg;

    typedef enum logic [1:0] {PC_HOLD, PC_INC, PC_LOAD} pc_op_t;
    typedef enum logic [1:0] {SP_HOLD, SP_PUSH, SP_PULL, SP_RELOAD} sp_op_t;
    typedef enum logic [2:0] {AM_NONE, AM_PC, AM_PUSH, AM_PULL, AM_IX0, AM_IX1, AM_IX2} addr_mode_t;
    typedef enum logic [1:0] {FRAME_NONE, FRAME_CALL, FRAME_IRQ} frame_t;

    typedef struct packed {
        logic acc_we;
        logic [7:0] acc_data;
        logic idx_we;
        logic [7:0] idx_data;
        pc_op_t pc_op;
        logic [15:0] pc_target;
        sp_op_t sp_op;
        addr_mode_t addr_mode;
        logic [15:0] operand;
        logic [7:0] wr_data;
        frame_t frame;
    } seq_cmd_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [7:0] data;
    } mem_req_t;

endpackage : cpu_regs_pkg

// *** rtl/stack_window.sv ***
// Six-bit wrapping stack pointer with fixed upper address bits
`timescale 1ns/100ps
`include "cpu_regs_defines.svh"
module stack_window #(
    parameter int SP_BITS = `STACK_PTR_BITS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire cpu_regs_pkg::sp_op_t op,
    output logic [SP_BITS-1:0] sp_q,
    output logic [15:0] push_addr,
    output logic [15:0] pull_addr
);
    import cpu_regs_pkg::*;

    logic [SP_BITS-1:0] sp_d;
    logic [SP_BITS-1:0] sp_inc;

    if (SP_BITS != 6) begin : g_check
        $error("stack_window serves a six-bit stack window only");
    end

    always_comb begin
        sp_inc = sp_q + SP_BITS'(1);
        sp_d = sp_q;
        unique case (op)
            SP_HOLD: sp_d = sp_q;
            SP_PUSH: sp_d = sp_q - SP_BITS'(1);
            SP_PULL: sp_d = sp_inc;
            SP_RELOAD: sp_d = `STACK_PTR_RESET;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sp_q <= `STACK_PTR_RESET;
        end else if (ce) begin
            sp_q <= sp_d;
        end
    end

    // Pull reads the byte above the free slot
    assign push_addr = {`STACK_FIXED_BITS, sp_q};
    assign pull_addr = {`STACK_FIXED_BITS, sp_inc};

endmodule : stack_window

// *** rtl/cpu_pointer_register_set.sv ***
// Accumulator, index, stack pointer and program counter of the core
//
// Contract
// - Core registers live inside, never memory mapped
// - Stack pointer has six bits, shown sixteen
// - Push below C0 wraps to FF
// - Stack address is fixed bits plus pointer
// - Reset and reload instruction set pointer FF
// - Decrement after push, increment before pull
// - Call stacks two bytes, interrupt five
// - Eight-bit accumulator untouched by reset
// - Unoffset indexed: high byte zero
// - Short offset indexed: index plus byte
// - Long offset indexed: index plus word
// - Index register is storage, untouched by reset
// - Sixteen-bit counter, bits above map ignored
// - Counter steps one per fetched byte
// - Jumps, branches, interrupts load counter target
// - Interrupt: push, set mask, load vector
`timescale 1ns/100ps
`include "cpu_regs_defines.svh"
module cpu_pointer_register_set #(
    parameter int ADDR_BITS = `MAP_ADDR_BITS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire cpu_regs_pkg::seq_cmd_t cmd,
    input wire logic [7:0] flags_in,
    output cpu_regs_pkg::mem_req_t mem_q,
    output logic busy_q,
    output logic mask_set_q,
    output logic [7:0] acc_q,
    output logic [7:0] idx_q,
    output logic [15:0] sp_out_q,
    output logic [15:0] pc_q
);
    import cpu_regs_pkg::*;

    typedef enum logic [1:0] {F_IDLE, F_PUSH, F_MASK, F_VECTOR} frame_state_t;

    if (ADDR_BITS < 8 || ADDR_BITS > 16) begin : g_check
        $error("ADDR_BITS must lie between 8 and 16");
    end

    // Truncates any address to the implemented map
    function automatic logic [15:0] map_addr(input logic [15:0] a);
        logic [15:0] m;
        m = (16'h0001 << ADDR_BITS) - 16'h0001;
        return a & m;
    endfunction : map_addr

    logic take;
    logic [7:0] acc_d;
    logic [7:0] idx_d;
    logic [15:0] pc_d;
    mem_req_t mem_d;
    frame_state_t fst_q, fst_d;
    frame_t fkind_q, fkind_d;
    logic [2:0] fcnt_q, fcnt_d;
    logic [15:0] ftarget_q, ftarget_d;
    logic [15:0] fret_q, fret_d;
    logic mask_set_d;
    sp_op_t sp_op;
    logic [5:0] sp;
    logic [15:0] push_addr;
    logic [15:0] pull_addr;
    logic [7:0] frame_byte;

    assign take = (fst_q == F_IDLE);

    // Pointer lives only in this core, never on the data bus decode
    stack_window #(
        .SP_BITS(`STACK_PTR_BITS)
    ) u_stack (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .op(sp_op),
        .sp_q(sp),
        .push_addr(push_addr),
        .pull_addr(pull_addr)
    );

    // Byte order on the stack: PCL, PCH, X, A, flags
    always_comb begin
        unique case (fcnt_q)
            3'h0: frame_byte = fret_q[7:0];
            3'h1: frame_byte = fret_q[15:8];
            3'h2: frame_byte = idx_q;
            3'h3: frame_byte = acc_q;
            default: frame_byte = flags_in;
        endcase
    end

    // Data registers
    always_comb begin
        acc_d = acc_q;
        idx_d = idx_q;
        if (take && cmd.acc_we) begin
            acc_d = cmd.acc_data;
        end
        if (take && cmd.idx_we) begin
            idx_d = cmd.idx_data;
        end
    end

    // No reset on data registers: contents survive device reset
    always_ff @(posedge clk) begin
        if (ce) begin
            acc_q <= acc_d;
            idx_q <= idx_d;
        end
    end

    // Frame sequencer, counter and stack operation
    always_comb begin
        fst_d = fst_q;
        fkind_d = fkind_q;
        fcnt_d = fcnt_q;
        ftarget_d = ftarget_q;
        fret_d = fret_q;
        mask_set_d = 1'b0;
        pc_d = pc_q;
        sp_op = SP_HOLD;
        unique case (fst_q)
            F_IDLE: begin
                unique case (cmd.pc_op)
                    PC_HOLD: pc_d = pc_q;
                    PC_INC: pc_d = map_addr(pc_q + 16'h0001);
                    PC_LOAD: pc_d = map_addr(cmd.pc_target);
                    default: pc_d = pc_q;
                endcase
                sp_op = cmd.sp_op;
                if (cmd.frame != FRAME_NONE) begin
                    fst_d = F_PUSH;
                    fkind_d = cmd.frame;
                    fcnt_d = 3'h0;
                    ftarget_d = cmd.pc_target;
                    fret_d = pc_q;
                    pc_d = pc_q;
                    sp_op = SP_HOLD;
                end
            end
            F_PUSH: begin
                sp_op = SP_PUSH;
                fcnt_d = fcnt_q + 3'h1;
                if (fkind_q == FRAME_IRQ && fcnt_q == `IRQ_FRAME_BYTES - 3'h1) begin
                    fst_d = F_MASK;
                end else if (fkind_q == FRAME_CALL && fcnt_q == `CALL_FRAME_BYTES - 3'h1) begin
                    fst_d = F_VECTOR;
                end
            end
            F_MASK: begin
                mask_set_d = 1'b1;
                fst_d = F_VECTOR;
            end
            F_VECTOR: begin
                pc_d = map_addr(ftarget_q);
                fst_d = F_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            fst_q <= F_IDLE;
            fkind_q <= FRAME_NONE;
            fcnt_q <= 3'h0;
            ftarget_q <= 16'h0000;
            fret_q <= 16'h0000;
            mask_set_q <= 1'b0;
            pc_q <= `PC_RESET_VALUE;
        end else if (ce) begin
            fst_q <= fst_d;
            fkind_q <= fkind_d;
            fcnt_q <= fcnt_d;
            ftarget_q <= ftarget_d;
            fret_q <= fret_d;
            mask_set_q <= mask_set_d;
            pc_q <= pc_d;
        end
    end

    // Memory request formation
    always_comb begin
        mem_d = '0;
        if (fst_q == F_PUSH) begin
            mem_d.valid = 1'b1;
            mem_d.write = 1'b1;
            mem_d.addr = map_addr(push_addr);
            mem_d.data = frame_byte;
        end else if (take) begin
            mem_d.valid = (cmd.addr_mode != AM_NONE);
            mem_d.data = cmd.wr_data;
            unique case (cmd.addr_mode)
                AM_NONE: mem_d.valid = 1'b0;
                AM_PC: mem_d.addr = pc_q;
                AM_PUSH: begin
                    mem_d.write = 1'b1;
                    mem_d.addr = map_addr(push_addr);
                end
                AM_PULL: mem_d.addr = map_addr(pull_addr);
                AM_IX0: mem_d.addr = {8'h00, idx_q};
                AM_IX1: mem_d.addr = map_addr({8'h00, idx_q} + {8'h00, cmd.operand[7:0]});
                AM_IX2: mem_d.addr = map_addr({8'h00, idx_q} + cmd.operand);
                default: mem_d.valid = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            mem_q <= '0;
            busy_q <= 1'b0;
            sp_out_q <= `STACK_TOP_ADDR;
        end else if (ce) begin
            mem_q <= mem_d;
            busy_q <= (fst_d != F_IDLE);
            sp_out_q <= {`STACK_FIXED_BITS, sp};
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn || !ce);

    logic reset_seen_q;
    always_ff @(posedge clk) begin
        reset_seen_q <= !resetn;
    end

    a_sp_reset_top: assert property (reset_seen_q && resetn |-> sp == `STACK_PTR_RESET)
        else $error("stack pointer not at top after reset");
    a_sp_reload: assert property (take && cmd.frame == FRAME_NONE && cmd.sp_op == SP_RELOAD
        |=> sp == `STACK_PTR_RESET)
        else $error("reload did not set stack top");
    a_sp_wrap_bottom: assert property (sp == 6'h00 && sp_op == SP_PUSH |=> sp == 6'h3F)
        else $error("stack pointer did not wrap to top");
    a_pull_preinc: assert property (take && cmd.frame == FRAME_NONE && cmd.addr_mode == AM_PULL
        |=> mem_q.addr[7:0] == {2'b11, $past(sp) + 6'h01})
        else $error("pull not at pointer plus one");
    a_stack_fixed: assert property (mem_q.write |-> mem_q.addr[15:6] == `STACK_FIXED_BITS)
        else $error("stack write outside window");
    a_irq_five: assert property (take && cmd.frame == FRAME_IRQ
        |=> ##1 mem_q.write[*5] ##1 (!mem_q.write && mask_set_q))
        else $error("interrupt frame not five bytes then mask");
    a_call_two: assert property (take && cmd.frame == FRAME_CALL
        |=> ##1 mem_q.write[*2] ##1 (!mem_q.write && !mask_set_q))
        else $error("call frame not two bytes");
    a_vector_load: assert property (mask_set_q |=> pc_q == map_addr($past(ftarget_q, 2)))
        else $error("vector not loaded after mask");
    a_pc_step: assert property (take && cmd.frame == FRAME_NONE && cmd.pc_op == PC_INC
        |=> pc_q == map_addr($past(pc_q) + 16'h0001))
        else $error("counter did not step by one");
    a_ix0_high_zero: assert property (take && cmd.frame == FRAME_NONE && cmd.addr_mode == AM_IX0
        |=> mem_q.valid && mem_q.addr == {8'h00, $past(idx_q)})
        else $error("unoffset indexed high byte not zero");
    a_ix2_sum: assert property (take && cmd.frame == FRAME_NONE && cmd.addr_mode == AM_IX2
        |=> mem_q.addr == map_addr({8'h00, $past(idx_q)} + $past(cmd.operand)))
        else $error("long offset address wrong");

    c_irq_entry: cover property (take && cmd.frame == FRAME_IRQ ##7 mask_set_q);
    c_call: cover property (take && cmd.frame == FRAME_CALL);
    c_wrap: cover property (sp == 6'h00 && sp_op == SP_PUSH);
    c_ix1: cover property (take && cmd.addr_mode == AM_IX1);

endmodule : cpu_pointer_register_set

// *** tb/seq_mem_model.sv ***
// Memory bus side of the sequencer: logs writes and mask requests
`timescale 1ns/100ps
module seq_mem_model
    import cpu_regs_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire cpu_regs_pkg::mem_req_t mem_q,
    input wire logic mask_set_q
);
    logic [15:0] wa[$];
    logic [7:0] wd[$];
    int n_mask = 0;
    int mask_at = 0;

    function automatic void clear();
        wa.delete();
        wd.delete();
        n_mask = 0;
    endfunction : clear

    // Writes land in the log; a mask pulse notes how many came first
    always @(posedge clk) begin
        if (resetn && mem_q.valid && mem_q.write) begin
            wa.push_back(mem_q.addr);
            wd.push_back(mem_q.data);
        end
        if (resetn && mask_set_q) begin
            n_mask++;
            mask_at = wa.size();
        end
    end
endmodule : seq_mem_model

// *** tb/cpu_pointer_register_set_tb.sv ***
// Self-checking bench for the pointer register set
`timescale 1ns/100ps
module cpu_pointer_register_set_tb;
    import cpu_regs_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    seq_cmd_t cmd = '0;
    logic [7:0] flags_in = 8'h00;
    mem_req_t mem_q;
    logic busy_q;
    logic mask_set_q;
    logic [7:0] acc_q;
    logic [7:0] idx_q;
    logic [15:0] sp_out_q;
    logic [15:0] pc_q;
    int n_errors = 0;
    int n_tests = 0;

    initial forever #50 clk = ~clk;

    cpu_pointer_register_set i_cpu_pointer_register_set (
        .clk(clk), .resetn(resetn), .ce(ce), .cmd(cmd), .flags_in(flags_in),
        .mem_q(mem_q), .busy_q(busy_q), .mask_set_q(mask_set_q), .acc_q(acc_q),
        .idx_q(idx_q), .sp_out_q(sp_out_q), .pc_q(pc_q)
    );

    seq_mem_model i_seq_mem_model (
        .clk(clk), .resetn(resetn), .mem_q(mem_q), .mask_set_q(mask_set_q)
    );

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One command taken at the next edge, idle after it
    task automatic step(seq_cmd_t c);
        @(negedge clk);
        cmd = c;
        @(negedge clk);
        cmd = '0;
    endtask : step

    task automatic frame(seq_cmd_t c);
        int i;
        step(c);
        check("busy", busy_q, 16'h0001);
        for (i = 0; i < 20 && busy_q !== 1'b0; i++) begin
            @(negedge clk);
        end
        if (i == 20) begin
            n_errors++;
            wrap_up();
        end
        @(negedge clk);
    endtask : frame

    task automatic fetch_run();
        seq_cmd_t c;
        c = '0;
        c.pc_op = PC_LOAD;
        c.pc_target = 16'hFFFE;
        step(c);
        check("pc load", pc_q, 16'h1FFE);
        c.pc_op = PC_INC;
        c.addr_mode = AM_PC;
        step(c);
        check("fetch addr", mem_q.addr, 16'h1FFE);
        check("pc inc", pc_q, 16'h1FFF);
        step(c);
        check("pc top wrap", pc_q, 16'h0000);
    endtask : fetch_run

    task automatic index_run();
        seq_cmd_t c;
        c = '0;
        c.idx_we = 1'b1;
        c.idx_data = 8'hF0;
        step(c);
        c = '0;
        c.addr_mode = AM_IX0;
        step(c);
        check("ix0 addr", mem_q.addr, 16'h00F0);
        c.addr_mode = AM_IX1;
        c.operand = 16'h0020;
        step(c);
        check("ix1 addr", mem_q.addr, 16'h0110);
        c.addr_mode = AM_IX2;
        c.operand = 16'h1FF0;
        step(c);
        check("ix2 addr", mem_q.addr, 16'h00E0);
    endtask : index_run

    // Sixty-five pushes run the window down and wrap once
    task automatic stack_run();
        seq_cmd_t c;
        c = '0;
        c.sp_op = SP_PUSH;
        c.addr_mode = AM_PUSH;
        for (int i = 0; i <= 64; i++) begin
            c.wr_data = 8'(i);
            step(c);
            check("push addr", mem_q.addr, {10'h003, 6'(63 - i)});
            check("push data", mem_q.data, c.wr_data);
            check("push write", mem_q.write, 16'h0001);
        end
        @(negedge clk);
        check("sp after wrap", sp_out_q, 16'h00FE);
        c = '0;
        c.sp_op = SP_PULL;
        c.addr_mode = AM_PULL;
        step(c);
        check("pull addr", mem_q.addr, 16'h00FF);
        check("pull read", mem_q.write, 16'h0000);
        c = '0;
        c.sp_op = SP_PUSH;
        step(c);
        c.sp_op = SP_RELOAD;
        step(c);
        @(negedge clk);
        check("sp reload", sp_out_q, 16'h00FF);
    endtask : stack_run

    task automatic frame_run();
        seq_cmd_t c;
        logic [7:0] exp_d[5] = '{8'h34, 8'h12, 8'h5A, 8'hA5, 8'hE3};
        c = '0;
        c.acc_we = 1'b1;
        c.acc_data = 8'hA5;
        c.idx_we = 1'b1;
        c.idx_data = 8'h5A;
        c.pc_op = PC_LOAD;
        c.pc_target = 16'h1234;
        step(c);
        check("acc write", acc_q, 16'h00A5);
        flags_in = 8'hE3;
        i_seq_mem_model.clear();
        c = '0;
        c.frame = FRAME_IRQ;
        c.pc_target = 16'h0400;
        frame(c);
        check("irq bytes", i_seq_mem_model.wa.size(), 5);
        for (int i = 0; i < 5; i++) begin
            check("irq addr", i_seq_mem_model.wa[i], 16'h00FF - i);
            check("irq data", i_seq_mem_model.wd[i], exp_d[i]);
        end
        check("mask count", i_seq_mem_model.n_mask, 1);
        check("mask after push", i_seq_mem_model.mask_at, 5);
        check("irq vector", pc_q, 16'h0400);
        check("sp after irq", sp_out_q, 16'h00FA);
        i_seq_mem_model.clear();
        c.frame = FRAME_CALL;
        c.pc_target = 16'h0800;
        frame(c);
        check("call bytes", i_seq_mem_model.wa.size(), 2);
        check("call pcl", i_seq_mem_model.wa[0], 16'h00FA);
        check("call pch", i_seq_mem_model.wd[1], 16'h0004);
        check("call mask", i_seq_mem_model.n_mask, 0);
        check("call target", pc_q, 16'h0800);
        check("sp after call", sp_out_q, 16'h00F8);
    endtask : frame_run

    // Clock enable low: a command must leave all state alone
    task automatic hold_run();
        seq_cmd_t c;
        c = '0;
        c.pc_op = PC_INC;
        c.sp_op = SP_PUSH;
        c.acc_we = 1'b1;
        c.acc_data = 8'h3C;
        @(negedge clk);
        ce = 1'b0;
        step(c);
        ce = 1'b1;
        @(negedge clk);
        check("pc frozen", pc_q, 16'h0800);
        check("acc frozen", acc_q, 16'h00A5);
        check("sp frozen", sp_out_q, 16'h00F8);
    endtask : hold_run

    // Second reset keeps data registers, restores pointers
    task automatic reset_run();
        @(negedge clk);
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        check("acc kept", acc_q, 16'h00A5);
        check("idx kept", idx_q, 16'h005A);
        check("sp reset", sp_out_q, 16'h00FF);
        check("pc reset", pc_q, 16'h0000);
        check("bus idle", mem_q.valid, 16'h0000);
    endtask : reset_run

    initial begin
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        check("sp start", sp_out_q, 16'h00FF);
        check("pc start", pc_q, 16'h0000);
        fetch_run();
        index_run();
        stack_run();
        frame_run();
        hold_run();
        reset_run();
        wrap_up();
    end
endmodule : cpu_pointer_register_set_tb
